/* design/spb_pkg.sv */
// spb_pkg: offsets, field positions, reset values and timing counts for the
// serial receive interface bring-up register bank.
// assumes a byte-wide configuration port decoding 12-bit register addresses.
//
// Behaviour
// - lane power-down bit x powers lane x down when one; unused lanes set.
// - termination calibration starts on a low-to-high edge of control bit 0.
// - group a control covers lanes 0,1,6,7; group b covers lanes 2..5.
// - each group's calibration code reads back in bits 3:0 of its code register.
// - override bit 4 clear selects autocalibrated code, set selects override value.
// - under override, bits 3:1 of override register replace the calibrated code.
// - each lane owns an offset register adjusting its termination in bits 3:0.
// - lane offset is signed magnitude, bit 3 sign, bits 2:0 magnitude.
// - byte rate is lane rate over ten; processing clock is byte rate over four.
// - frame rate is byte rate over octets per frame; ratio to processing is 4/F.
// - pll oscillator clock divided by two gives the deserializer quadrature clock.
// - pll reference is lane rate over forty; divider puts pfd in 35..80 MHz.
// - a rising edge of synthesizer control bit 2 starts a pll recalibration.
// - pll status bit 0 reports lock, bit 3 reports successful calibration.
// - status bits 4 and 5 flag calibration band limits; software then recalibrates.

package spb_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [11:0] ADDR_REF_CLOCK_RATE_SELECT = 12'h0084;
  localparam logic [11:0] ADDR_SERIAL_INTERFACE_POWER = 12'h0200;
  localparam logic [11:0] ADDR_LANE_POWER_DOWN        = 12'h0201;
  localparam logic [11:0] ADDR_SYNTH_ENABLE_RECAL     = 12'h0280;
  localparam logic [11:0] ADDR_SYNTH_STATUS           = 12'h0281;
  localparam logic [11:0] ADDR_PFD_DIVIDER_SELECT     = 12'h0289;
  localparam logic [11:0] ADDR_TERM_CAL_CTRL_GROUP_A  = 12'h02a7;
  localparam logic [11:0] ADDR_TERM_OVERRIDE_GROUP_A  = 12'h02a8;
  localparam logic [11:0] ADDR_TERM_CAL_CODE_GROUP_A  = 12'h02ac;
  localparam logic [11:0] ADDR_TERM_CAL_CTRL_GROUP_B  = 12'h02ae;
  localparam logic [11:0] ADDR_TERM_OVERRIDE_GROUP_B  = 12'h02af;
  localparam logic [11:0] ADDR_TERM_CAL_CODE_GROUP_B  = 12'h02b3;
  localparam logic [11:0] ADDR_TERM_OFFSET_LANE0      = 12'h02bb;
  localparam logic [11:0] ADDR_TERM_OFFSET_LANE7      = 12'h02c2;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int INTERFACE_POWER_DOWN_BIT = 0;
  localparam int TERM_CAL_START_BIT       = 0;
  localparam int OVERRIDE_SELECT_BIT      = 4;
  localparam int OVERRIDE_VALUE_LSB       = 1;
  localparam int OFFSET_SIGN_BIT          = 3;
  localparam int SYNTH_ENABLE_BIT         = 0;
  localparam int SYNTH_RECAL_BIT          = 2;
  localparam int STATUS_LOCK_BIT          = 0;
  localparam int STATUS_CAL_OK_BIT        = 3;
  localparam int STATUS_BAND_LOW_BIT      = 4;
  localparam int STATUS_BAND_HIGH_BIT     = 5;
  localparam int REF_RATE_LSB             = 4;

  // lanes 0,1,6,7 follow group a, the rest group b
  localparam logic [7:0] GROUP_A_LANE_MASK = 8'hc3;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_INTERFACE_POWER = 8'h01;
  localparam logic [7:0] RST_LANE_POWER_DOWN = 8'hff;
  localparam logic [7:0] RST_ZERO            = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // rate relationships, as fixed divide ratios
  localparam logic [3:0] BYTE_PER_LANE_DIV = 4'h0a;
  localparam logic [3:0] PCLK_PER_BYTE_DIV = 4'h04;
  localparam logic [3:0] VCO_TO_QUAD_DIV   = 4'h02;
  localparam logic [7:0] REF_PER_LANE_DIV  = 8'h28;

  // pfd divider codes
  localparam logic [1:0] PFD_DIV_CODE_4 = 2'b00;
  localparam logic [1:0] PFD_DIV_CODE_2 = 2'b01;
  localparam logic [1:0] PFD_DIV_CODE_1 = 2'b10;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int TERM_CAL_TIME_NS = 1000;
  localparam int TERM_CAL_CYCLES  = (TERM_CAL_TIME_NS * 1000) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    SPB_CAL_IDLE = 2'b00,
    SPB_CAL_RUN  = 2'b01,
    SPB_CAL_DONE = 2'b10
  } spb_cal_state_t;

endpackage

/* design/spb_bringup.sv */
// spb_bringup: register bank and control for receive-side serial interface
// bring-up: power, termination calibration and override, lane offsets, pll.
// assumes a synchronous byte-wide configuration port already deserialised from
// the serial configuration pins, and analog calibration results on plain inputs.

`timescale 1ns/10ps
`default_nettype none

module spb_bringup
#(
  parameter int LANES           = 8,
  parameter int TERM_CAL_CYCLES = spb_pkg::TERM_CAL_CYCLES
)
(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // configuration port
  input  wire logic [11:0] cfg_addr_in,
  input  wire logic        cfg_wr_in,
  input  wire logic [7:0]  cfg_wdata_in,
  input  wire logic        cfg_rd_in,
  output logic      [7:0]  cfg_rdata_out,
  output logic             cfg_rvalid_out,
  // analog termination calibration result per group (a, b)
  input  wire logic [3:0]  term_cal_result_a_in,
  input  wire logic [3:0]  term_cal_result_b_in,
  // pll analog status
  input  wire logic        pll_lock_in,
  input  wire logic        pll_cal_ok_in,
  input  wire logic        pll_band_low_in,
  input  wire logic        pll_band_high_in,
  // link framing, octets per frame per lane (1, 2 or 4)
  input  wire logic [2:0]  octets_per_frame_in,
  // power and termination control to the lanes
  output logic             interface_power_down_out,
  output logic [7:0]       lane_power_down_mask_out,
  output logic [4*8-1:0]   lane_term_code_out,
  output logic             term_cal_busy_out,
  // pll control
  output logic             pll_enable_out,
  output logic             pll_recal_pulse_out,
  output logic [1:0]       pfd_input_divider_out,
  output logic [1:0]       ref_rate_select_out,
  output logic [2:0]       pfd_divide_ratio_out,
  // rate relationships
  output logic [3:0]       byte_div_out,
  output logic [3:0]       pclk_div_out,
  output logic [3:0]       quad_clk_div_out,
  output logic [7:0]       ref_div_out,
  output logic [2:0]       frames_per_pclk_out
);

  // elaboration-time parameter checks
  if (LANES != 8)
  begin
    $error("spb_bringup serves exactly eight lanes");
  end
  if (TERM_CAL_CYCLES < 1)
  begin
    $error("spb_bringup calibration time must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0]  ref_clock_rate_select_q;
  logic [7:0]  serial_interface_power_q;
  logic [7:0]  lane_power_down_q;
  logic [7:0]  synth_enable_recal_q;
  logic [7:0]  pfd_divider_select_q;
  logic [7:0]  term_cal_ctrl_a_q;
  logic [7:0]  term_cal_ctrl_b_q;
  logic [7:0]  term_override_a_q;
  logic [7:0]  term_override_b_q;
  logic [3:0]  term_cal_code_a_q;
  logic [3:0]  term_cal_code_b_q;
  logic [7:0]  term_offset_q [8];
  logic [7:0]  synth_status_q;

  logic        wr_term_offset;
  logic [2:0]  offset_index;

  assign wr_term_offset = cfg_wr_in &&
                          (cfg_addr_in >= spb_pkg::ADDR_TERM_OFFSET_LANE0) &&
                          (cfg_addr_in <= spb_pkg::ADDR_TERM_OFFSET_LANE7);
  assign offset_index   = 3'(cfg_addr_in - spb_pkg::ADDR_TERM_OFFSET_LANE0);

  // writes to status and code offsets fall through the decode untouched
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      ref_clock_rate_select_q  <= spb_pkg::RST_ZERO;
      serial_interface_power_q <= spb_pkg::RST_INTERFACE_POWER;
      lane_power_down_q        <= spb_pkg::RST_LANE_POWER_DOWN;
      synth_enable_recal_q     <= spb_pkg::RST_ZERO;
      pfd_divider_select_q     <= spb_pkg::RST_ZERO;
      term_cal_ctrl_a_q        <= spb_pkg::RST_ZERO;
      term_cal_ctrl_b_q        <= spb_pkg::RST_ZERO;
      term_override_a_q        <= spb_pkg::RST_ZERO;
      term_override_b_q        <= spb_pkg::RST_ZERO;
    end
    else if (cfg_wr_in)
    begin
      unique case (cfg_addr_in)
        spb_pkg::ADDR_REF_CLOCK_RATE_SELECT:  ref_clock_rate_select_q  <= cfg_wdata_in;
        spb_pkg::ADDR_SERIAL_INTERFACE_POWER: serial_interface_power_q <= cfg_wdata_in;
        spb_pkg::ADDR_LANE_POWER_DOWN:        lane_power_down_q        <= cfg_wdata_in;
        spb_pkg::ADDR_SYNTH_ENABLE_RECAL:     synth_enable_recal_q     <= cfg_wdata_in;
        spb_pkg::ADDR_PFD_DIVIDER_SELECT:     pfd_divider_select_q     <= cfg_wdata_in;
        spb_pkg::ADDR_TERM_CAL_CTRL_GROUP_A:  term_cal_ctrl_a_q        <= cfg_wdata_in;
        spb_pkg::ADDR_TERM_CAL_CTRL_GROUP_B:  term_cal_ctrl_b_q        <= cfg_wdata_in;
        spb_pkg::ADDR_TERM_OVERRIDE_GROUP_A:  term_override_a_q        <= cfg_wdata_in;
        spb_pkg::ADDR_TERM_OVERRIDE_GROUP_B:  term_override_b_q        <= cfg_wdata_in;
        default:                              ;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < 8; i++)
        term_offset_q[i] <= spb_pkg::RST_ZERO;
    end
    else if (wr_term_offset)
    begin
      term_offset_q[offset_index] <= cfg_wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path: one cycle after the strobe, unmapped reads return zero
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      cfg_rdata_out  <= spb_pkg::RST_ZERO;
      cfg_rvalid_out <= 1'b0;
    end
    else
    begin
      cfg_rvalid_out <= cfg_rd_in;
      if (cfg_rd_in)
      begin
        if ((cfg_addr_in >= spb_pkg::ADDR_TERM_OFFSET_LANE0) &&
            (cfg_addr_in <= spb_pkg::ADDR_TERM_OFFSET_LANE7))
          cfg_rdata_out <= term_offset_q[offset_index];
        else
        begin
          unique case (cfg_addr_in)
            spb_pkg::ADDR_REF_CLOCK_RATE_SELECT:  cfg_rdata_out <= ref_clock_rate_select_q;
            spb_pkg::ADDR_SERIAL_INTERFACE_POWER: cfg_rdata_out <= serial_interface_power_q;
            spb_pkg::ADDR_LANE_POWER_DOWN:        cfg_rdata_out <= lane_power_down_q;
            spb_pkg::ADDR_SYNTH_ENABLE_RECAL:     cfg_rdata_out <= synth_enable_recal_q;
            spb_pkg::ADDR_SYNTH_STATUS:           cfg_rdata_out <= synth_status_q;
            spb_pkg::ADDR_PFD_DIVIDER_SELECT:     cfg_rdata_out <= pfd_divider_select_q;
            spb_pkg::ADDR_TERM_CAL_CTRL_GROUP_A:  cfg_rdata_out <= term_cal_ctrl_a_q;
            spb_pkg::ADDR_TERM_CAL_CTRL_GROUP_B:  cfg_rdata_out <= term_cal_ctrl_b_q;
            spb_pkg::ADDR_TERM_OVERRIDE_GROUP_A:  cfg_rdata_out <= term_override_a_q;
            spb_pkg::ADDR_TERM_OVERRIDE_GROUP_B:  cfg_rdata_out <= term_override_b_q;
            spb_pkg::ADDR_TERM_CAL_CODE_GROUP_A:  cfg_rdata_out <= {4'h0, term_cal_code_a_q};
            spb_pkg::ADDR_TERM_CAL_CODE_GROUP_B:  cfg_rdata_out <= {4'h0, term_cal_code_b_q};
            default:                              cfg_rdata_out <= spb_pkg::RST_ZERO;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // termination autocalibration, one sequencer per lane group
  logic                 cal_start_a_prev_q;
  logic                 cal_start_b_prev_q;
  logic                 cal_rise_a;
  logic                 cal_rise_b;
  spb_pkg::spb_cal_state_t cal_state_a_q;
  spb_pkg::spb_cal_state_t cal_state_b_q;
  logic [31:0]          cal_count_a_q;
  logic [31:0]          cal_count_b_q;

  assign cal_rise_a = term_cal_ctrl_a_q[spb_pkg::TERM_CAL_START_BIT] && !cal_start_a_prev_q;
  assign cal_rise_b = term_cal_ctrl_b_q[spb_pkg::TERM_CAL_START_BIT] && !cal_start_b_prev_q;

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      cal_start_a_prev_q <= 1'b0;
      cal_start_b_prev_q <= 1'b0;
    end
    else
    begin
      cal_start_a_prev_q <= term_cal_ctrl_a_q[spb_pkg::TERM_CAL_START_BIT];
      cal_start_b_prev_q <= term_cal_ctrl_b_q[spb_pkg::TERM_CAL_START_BIT];
    end
  end

  // a new edge during a run restarts it, so the latest request always wins
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      cal_state_a_q     <= spb_pkg::SPB_CAL_IDLE;
      cal_count_a_q     <= '0;
      term_cal_code_a_q <= 4'h0;
    end
    else if (cal_rise_a)
    begin
      cal_state_a_q <= spb_pkg::SPB_CAL_RUN;
      cal_count_a_q <= '0;
    end
    else
    begin
      unique case (cal_state_a_q)
        spb_pkg::SPB_CAL_IDLE: ;
        spb_pkg::SPB_CAL_RUN:
        begin
          if (cal_count_a_q == 32'(TERM_CAL_CYCLES - 1))
          begin
            term_cal_code_a_q <= term_cal_result_a_in;
            cal_state_a_q     <= spb_pkg::SPB_CAL_DONE;
          end
          else
            cal_count_a_q <= cal_count_a_q + 32'd1;
        end
        spb_pkg::SPB_CAL_DONE: ;
        default: cal_state_a_q <= spb_pkg::SPB_CAL_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      cal_state_b_q     <= spb_pkg::SPB_CAL_IDLE;
      cal_count_b_q     <= '0;
      term_cal_code_b_q <= 4'h0;
    end
    else if (cal_rise_b)
    begin
      cal_state_b_q <= spb_pkg::SPB_CAL_RUN;
      cal_count_b_q <= '0;
    end
    else
    begin
      unique case (cal_state_b_q)
        spb_pkg::SPB_CAL_IDLE: ;
        spb_pkg::SPB_CAL_RUN:
        begin
          if (cal_count_b_q == 32'(TERM_CAL_CYCLES - 1))
          begin
            term_cal_code_b_q <= term_cal_result_b_in;
            cal_state_b_q     <= spb_pkg::SPB_CAL_DONE;
          end
          else
            cal_count_b_q <= cal_count_b_q + 32'd1;
        end
        spb_pkg::SPB_CAL_DONE: ;
        default: cal_state_b_q <= spb_pkg::SPB_CAL_IDLE;
      endcase
    end
  end

  assign term_cal_busy_out = (cal_state_a_q == spb_pkg::SPB_CAL_RUN) ||
                             (cal_state_b_q == spb_pkg::SPB_CAL_RUN);

  ////////////////////////////////////////////////////////////////////////////////
  // per-lane termination: base code, then signed-magnitude offset, saturated
  logic [3:0] base_a;
  logic [3:0] base_b;

  assign base_a = term_override_a_q[spb_pkg::OVERRIDE_SELECT_BIT]
                ? {1'b0, term_override_a_q[spb_pkg::OVERRIDE_VALUE_LSB +: 3]}
                : term_cal_code_a_q;
  assign base_b = term_override_b_q[spb_pkg::OVERRIDE_SELECT_BIT]
                ? {1'b0, term_override_b_q[spb_pkg::OVERRIDE_VALUE_LSB +: 3]}
                : term_cal_code_b_q;

  // registered so the analog trim never sees decode glitches
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      lane_term_code_out <= '0;
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        logic [4:0] base;
        logic [4:0] mag;
        base = {1'b0, spb_pkg::GROUP_A_LANE_MASK[i] ? base_a : base_b};
        mag  = {2'b00, term_offset_q[i][2:0]};
        if (term_offset_q[i][spb_pkg::OFFSET_SIGN_BIT])
          lane_term_code_out[4*i +: 4] <= (base < mag) ? 4'h0 : 4'(base - mag);
        else if ((base + mag) > 5'd15)
          lane_term_code_out[4*i +: 4] <= 4'hf;
        else
          lane_term_code_out[4*i +: 4] <= 4'(base + mag);
      end
    end
  end

  assign interface_power_down_out = serial_interface_power_q[spb_pkg::INTERFACE_POWER_DOWN_BIT];
  assign lane_power_down_mask_out = lane_power_down_q;

  ////////////////////////////////////////////////////////////////////////////////
  // serdes pll control and status
  logic recal_prev_q;

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      recal_prev_q        <= 1'b0;
      pll_recal_pulse_out <= 1'b0;
    end
    else
    begin
      recal_prev_q        <= synth_enable_recal_q[spb_pkg::SYNTH_RECAL_BIT];
      pll_recal_pulse_out <= synth_enable_recal_q[spb_pkg::SYNTH_RECAL_BIT] && !recal_prev_q;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      synth_status_q <= spb_pkg::RST_ZERO;
    else
    begin
      synth_status_q                               <= spb_pkg::RST_ZERO;
      synth_status_q[spb_pkg::STATUS_LOCK_BIT]      <= pll_lock_in;
      synth_status_q[spb_pkg::STATUS_CAL_OK_BIT]    <= pll_cal_ok_in;
      synth_status_q[spb_pkg::STATUS_BAND_LOW_BIT]  <= pll_band_low_in;
      synth_status_q[spb_pkg::STATUS_BAND_HIGH_BIT] <= pll_band_high_in;
    end
  end

  assign pll_enable_out        = synth_enable_recal_q[spb_pkg::SYNTH_ENABLE_BIT];
  assign pfd_input_divider_out = pfd_divider_select_q[1:0];
  assign ref_rate_select_out   = ref_clock_rate_select_q[spb_pkg::REF_RATE_LSB +: 2];

  // code 0b11 is undefined; treated as divide by one
  always_comb
  begin
    unique case (pfd_divider_select_q[1:0])
      spb_pkg::PFD_DIV_CODE_4: pfd_divide_ratio_out = 3'd4;
      spb_pkg::PFD_DIV_CODE_2: pfd_divide_ratio_out = 3'd2;
      default:                 pfd_divide_ratio_out = 3'd1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clock rate relationships
  assign byte_div_out     = spb_pkg::BYTE_PER_LANE_DIV;
  assign pclk_div_out     = spb_pkg::PCLK_PER_BYTE_DIV;
  assign quad_clk_div_out = spb_pkg::VCO_TO_QUAD_DIV;
  assign ref_div_out      = spb_pkg::REF_PER_LANE_DIV;

  // only f of 1, 2 and 4 gives a whole ratio; others read zero
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      frames_per_pclk_out <= 3'd0;
    else
    begin
      unique case (octets_per_frame_in)
        3'd1:    frames_per_pclk_out <= 3'd4;
        3'd2:    frames_per_pclk_out <= 3'd2;
        3'd4:    frames_per_pclk_out <= 3'd1;
        default: frames_per_pclk_out <= 3'd0;
      endcase
    end
  end

endmodule

`default_nettype wire

/* test/spb_chk.sv */
// spb_chk: concurrent checks on the bring-up register bank ports.
// assumes binding onto spb_bringup; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module spb_chk
(
  // clock, reset and configuration port
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic [11:0] cfg_addr_in,
  input wire logic        cfg_wr_in,
  input wire logic [7:0]  cfg_wdata_in,
  input wire logic        cfg_rd_in,
  input wire logic [7:0]  cfg_rdata_out,
  // analog status and framing
  input wire logic        pll_lock_in,
  input wire logic        pll_cal_ok_in,
  input wire logic        pll_band_low_in,
  input wire logic        pll_band_high_in,
  input wire logic [2:0]  octets_per_frame_in,
  // controls
  input wire logic [7:0]  lane_power_down_mask_out,
  input wire logic        term_cal_busy_out,
  input wire logic        pll_recal_pulse_out,
  input wire logic [1:0]  pfd_input_divider_out,
  input wire logic [2:0]  pfd_divide_ratio_out,
  input wire logic [3:0]  byte_div_out,
  input wire logic [3:0]  pclk_div_out,
  input wire logic [3:0]  quad_clk_div_out,
  input wire logic [7:0]  ref_div_out,
  input wire logic [2:0]  frames_per_pclk_out
);
  logic       cal_a_q;
  logic       recal_q;
  logic       cal_rise;
  logic       rc_rise;
  logic [2:0] fr_exp;
  // shadows of the start bits, so only a true 0->1 write counts as an edge
  assign cal_rise = cfg_wr_in && cfg_addr_in == 12'h02a7 && cfg_wdata_in[0] && !cal_a_q;
  assign rc_rise  = cfg_wr_in && cfg_addr_in == 12'h0280 && cfg_wdata_in[2] && !recal_q;
  assign fr_exp   = octets_per_frame_in == 3'h1 ? 3'h4 : octets_per_frame_in == 3'h2 ? 3'h2
                  : octets_per_frame_in == 3'h4 ? 3'h1 : 3'h0;
  always_ff @(posedge mclk_in)
    cal_a_q <= !rst_n_in ? 1'b0 : cfg_wr_in && cfg_addr_in == 12'h02a7 ? cfg_wdata_in[0] : cal_a_q;
  always_ff @(posedge mclk_in)
    recal_q <= !rst_n_in ? 1'b0 : cfg_wr_in && cfg_addr_in == 12'h0280 ? cfg_wdata_in[2] : recal_q;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  lane_mask_a: assert property (cfg_wr_in && cfg_addr_in == 12'h0201
    |=> lane_power_down_mask_out == $past(cfg_wdata_in)) else $error("lane mask not written");
  cal_start_a: assert property (cal_rise |-> ##2 term_cal_busy_out)
    else $error("calibration did not start");
  recal_edge_a: assert property (rc_rise |-> ##2 pll_recal_pulse_out)
    else $error("recal pulse missing");
  recal_cause_a: assert property (pll_recal_pulse_out |-> $past(rc_rise, 2))
    else $error("recal pulse without edge");
  status_a: assert property ($past(rst_n_in) && cfg_rd_in && cfg_addr_in == 12'h0281
    |=> cfg_rdata_out == {2'b00, $past(pll_band_high_in, 2), $past(pll_band_low_in, 2),
    $past(pll_cal_ok_in, 2), 2'b00, $past(pll_lock_in, 2)}) else $error("status bits wrong");
  rate_divs_a: assert property ({byte_div_out, pclk_div_out, quad_clk_div_out, ref_div_out}
    == 20'ha_4228) else $error("rate dividers wrong");
  frame_ratio_a: assert property ($past(rst_n_in) |-> frames_per_pclk_out == $past(fr_exp))
    else $error("frame ratio wrong");
  pfd_decode_a: assert property (pfd_divide_ratio_out == (pfd_input_divider_out == 2'b00
    ? 3'h4 : pfd_input_divider_out == 2'b01 ? 3'h2 : 3'h1)) else $error("pfd ratio wrong");
endmodule
bind spb_bringup spb_chk chk (.mclk_in, .rst_n_in, .cfg_addr_in, .cfg_wr_in, .cfg_wdata_in,
  .cfg_rd_in, .cfg_rdata_out, .pll_lock_in, .pll_cal_ok_in, .pll_band_low_in,
  .pll_band_high_in, .octets_per_frame_in, .lane_power_down_mask_out, .term_cal_busy_out,
  .pll_recal_pulse_out, .pfd_input_divider_out, .pfd_divide_ratio_out, .byte_div_out,
  .pclk_div_out, .quad_clk_div_out, .ref_div_out, .frames_per_pclk_out);
`default_nettype wire

/* test/spb_pll_model.sv */
// spb_pll_model: analog side of the bank: pll lock, band flag, cal codes.
// assumes the bench raises a band-limit event through band_force_in.
`timescale 1ns/10ps
`default_nettype none
module spb_pll_model
#(
  parameter logic [3:0] CODE_A   = 4'h3,
  parameter logic [3:0] CODE_B   = 4'h8,
  parameter int         LOCK_DLY = 20
)
(
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  // control from the bank and bench
  input  wire logic       pll_enable_in,
  input  wire logic       recal_pulse_in,
  input  wire logic       band_force_in,
  // analog results
  output logic      [3:0] cal_a_out,
  output logic      [3:0] cal_b_out,
  output logic            lock_out,
  output logic            band_high_out
);
  int cnt_q;
  assign cal_a_out = CODE_A;
  assign cal_b_out = CODE_B;
  assign lock_out  = pll_enable_in && cnt_q >= LOCK_DLY;
  // a recalibration drops lock, so software must wait for it again
  always_ff @(posedge mclk_in)
    cnt_q <= (!rst_n_in || !pll_enable_in || recal_pulse_in) ? 0
           : cnt_q < LOCK_DLY ? cnt_q + 1 : cnt_q;
  always_ff @(posedge mclk_in)
    band_high_out <= (!rst_n_in || recal_pulse_in) ? 1'b0 : band_force_in | band_high_out;
endmodule
`default_nettype wire

/* test/serdes_phy_bringup_control_tb.sv */
// serdes_phy_bringup_control_tb: register-level tests of the bring-up bank.
// assumes spb_pkg, spb_bringup, spb_pll_model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module serdes_phy_bringup_control_tb;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] addr = 12'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [2:0]  opf = 3'h1;
  logic        band_f = 1'b0;
  logic        band_lo = 1'b0;
  logic [7:0]  rdata, lpd, rdiv;
  logic        rvalid, pd, busy, en, recal, lock, b_hi;
  logic [31:0] code;
  logic [1:0]  pfd, rsel;
  logic [2:0]  ratio, fpp;
  logic [3:0]  bdiv, pdiv, qdiv, res_a, res_b;
  logic [6:0]  bands [4] = '{7'h31, 7'h11, 7'h0a, 7'h04};
  int          err_total = 0;
  int          n_tests = 0;
  int          cnt;
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  spb_bringup #(.TERM_CAL_CYCLES(4)) dut (.mclk_in(mclk), .rst_n_in(rst_n),
    .cfg_addr_in(addr), .cfg_wr_in(wr), .cfg_wdata_in(wdata), .cfg_rd_in(rd),
    .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid), .term_cal_result_a_in(res_a),
    .term_cal_result_b_in(res_b), .pll_lock_in(lock), .pll_cal_ok_in(lock),
    .pll_band_low_in(band_lo), .pll_band_high_in(b_hi), .octets_per_frame_in(opf),
    .interface_power_down_out(pd), .lane_power_down_mask_out(lpd), .lane_term_code_out(code),
    .term_cal_busy_out(busy), .pll_enable_out(en), .pll_recal_pulse_out(recal),
    .pfd_input_divider_out(pfd), .ref_rate_select_out(rsel), .pfd_divide_ratio_out(ratio),
    .byte_div_out(bdiv), .pclk_div_out(pdiv), .quad_clk_div_out(qdiv), .ref_div_out(rdiv),
    .frames_per_pclk_out(fpp));
  spb_pll_model model (.mclk_in(mclk), .rst_n_in(rst_n), .pll_enable_in(en),
    .recal_pulse_in(recal), .band_force_in(band_f), .cal_a_out(res_a), .cal_b_out(res_b),
    .lock_out(lock), .band_high_out(b_hi));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHK({rvalid, rdata}, {1'b1, e});
  endtask
  // bounded wait: calibration idle and, if asked, pll locked
  task automatic wait_ready(input logic want_lock);
    int i;
    for (i = 0; i < 200; i++)
    begin
      @(posedge mclk);
      #1;
      if (busy === 1'b0 && (lock === 1'b1 || !want_lock))
        break;
    end
    if (i == 200)
    begin
      err_total++;
      end_sim();
    end
    repeat (2) @(posedge mclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg(12'h0200, 8'h01);
    rd_reg(12'h0201, 8'hff);
    wr_reg(12'h0200, 8'h00);
    wr_reg(12'h0201, 8'hf0);
    `CHK({pd, lpd}, 9'h0f0);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(12'h0084, {2'b00, bands[i][6:5], 4'h0});
      wr_reg(12'h0289, {6'h00, bands[i][4:3]});
      `CHK({rsel, pfd, ratio}, bands[i]);
    end
    wr_reg(12'h0280, 8'h01);
    wait_ready(1'b1);
    rd_reg(12'h0281, 8'h09);
    @(posedge mclk);
    band_f <= 1'b1;
    @(posedge mclk);
    band_f <= 1'b0;
    rd_reg(12'h0281, 8'h29);
    @(posedge mclk);
    band_lo <= 1'b1;
    rd_reg(12'h0281, 8'h39);
    @(posedge mclk);
    band_lo <= 1'b0;
    wr_reg(12'h0280, 8'h05);
    cnt = 0;
    repeat (4)
    begin
      @(posedge mclk);
      #1;
      cnt += int'(recal === 1'b1);
    end
    wr_reg(12'h0280, 8'h01);
    `CHK(cnt, 1);
    wait_ready(1'b1);
    rd_reg(12'h0281, 8'h09);
    wr_reg(12'h02a7, 8'h01);
    wr_reg(12'h02ae, 8'h01);
    wait_ready(1'b0);
    rd_reg(12'h02ac, 8'h03);
    rd_reg(12'h02b3, 8'h08);
    `CHK(code, 32'h3388_8833);
    wr_reg(12'h02a7, 8'h01);
    @(posedge mclk);
    #1;
    `CHK(busy, 1'b0);
    wr_reg(12'h02a8, 8'h1a);
    wait_ready(1'b0);
    `CHK(code, 32'h5588_8855);
    wr_reg(12'h02a8, 8'h0a);
    wr_reg(12'h02bb, 8'h0f);
    wr_reg(12'h02bd, 8'h03);
    wr_reg(12'h02be, 8'h0a);
    wr_reg(12'h02bf, 8'h07);
    wr_reg(12'h02c0, 8'h0f);
    wait_ready(1'b0);
    `CHK(code, 32'h331f_6b30);
    wr_reg(12'h0281, 8'hff);
    wr_reg(12'h02ac, 8'hff);
    rd_reg(12'h02ac, 8'h03);
    rd_reg(12'h0281, 8'h09);
    rd_reg(12'h03ff, 8'h00);
    for (int f = 1; f < 6; f++)
    begin
      @(posedge mclk);
      opf <= 3'(f);
      repeat (2) @(posedge mclk);
      #1;
      `CHK(fpp, (f == 1 || f == 2 || f == 4) ? 4 / f : 0);
    end
    `CHK({bdiv, pdiv, qdiv, rdiv}, 20'ha_4228);
    end_sim();
  end
endmodule
`default_nettype wire
